// ==== gpmc_core.sv ====
// module: power-mode state machine of the positioning receiver
//
// Operation
// - full-on alone enters low-power modes; those return only to full-on
// - both supplies valid enters full-on with default feature settings
// - full-on acquires first, then moves to tracking by itself
// - serial rate resets to 9600 and accepts 4800 to 115200
// - update rate resets to one per second, configurable one to ten
// - default sentence set is the six standard sentences plus text
// - orbit prediction forced off when update rate exceeds one
// - standby command with zero enters standby
// - standby powers down radio and oscillator, no position sentences
// - any received byte in standby wakes to full-on
// - leaving standby reuses retained aiding data for hot start
// - permanent backup command drives power-cut output low
// - power-cut output is open drain, never driven high, only pulled low
// - backup stops navigation, ignores serial, keeps retained memory
// - periodic type one selects backup, type two selects standby
// - periodic mode alternates on and sleep periods in milliseconds
// - fields four and five give extended on and sleep periods
// - after failed fix use extended periods until fix returns
// - power mode zero leaves periodic standby anytime, backup only on
`timescale 1ns/1ps
module gpmc_core
  import gpmc_pkg::*;
#(
  parameter int unsigned ACQ_CYC = ACQ_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        MAIN_SUPPLY_OK,
  input  wire logic        BACKUP_SUPPLY_OK,
  input  wire logic        HOST_POWER_REQUEST,
  input  wire logic        RX_BYTE_VALID,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_CHECKSUM_OK,
  input  wire logic [3:0]  CMD_CODE,
  input  wire logic [3:0]  CMD_ARG,
  input  wire logic [31:0] CMD_RUN_MS,
  input  wire logic [31:0] CMD_SLEEP_MS,
  input  wire logic [31:0] CMD_EXT_RUN_MS,
  input  wire logic [31:0] CMD_EXT_SLEEP_MS,
  input  wire logic        FIX_VALID,
  output logic             CMD_ACK,
  output logic             CMD_NAK,
  output logic [2:0]       MODE,
  output logic             TRACKING,
  output logic             RF_POWER_EN,
  output logic             OSC_POWER_EN,
  output logic             NAV_EN,
  output logic             SENTENCE_EN,
  output logic [6:0]       SENTENCE_MASK,
  output logic             SERIAL_RX_EN,
  output logic             RETAIN_AIDING,
  output logic             HOT_START,
  output logic [2:0]       BAUD_SEL,
  output logic [3:0]       UPDATE_RATE,
  output logic             AUGMENT_EN,
  output logic             INTERFERENCE_CANCEL_EN,
  output logic             POSITION_LOGGING_EN,
  output logic             ORBIT_PREDICTION_EN,
  output logic             POWER_CUT_OUT,
  output logic             POWER_CUT_OE,
  output logic             SLEEP_PHASE,
  output logic             EXTENDED_PERIODS
);
  if (ACQ_CYC < 1) begin : g_bad_acq
    $error("ACQ_CYC must be at least one");
  end

  // ****************************************
  // pin synchronisation
  // ****************************************
  gpmc_sync_if sync ();

  gpmc_pin_sync u_sync (
    .clk         (REF_CLK),
    .rst         (SYS_RST),
    .main_pin    (MAIN_SUPPLY_OK),
    .backup_pin  (BACKUP_SUPPLY_OK),
    .request_pin (HOST_POWER_REQUEST),
    .sync        (sync.src)
  );

  logic supplies_ok;
  logic request_prev_q;
  logic request_rise;
  assign supplies_ok  = sync.main_ok & sync.backup_ok;
  assign request_rise = sync.power_request & ~request_prev_q;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      request_prev_q <= 1'b0;
    end else begin
      request_prev_q <= sync.power_request;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  gpmc_mode_type mode_q;
  logic          powered_q;
  logic          cmd_ok;
  logic          cmd_standby;
  logic          cmd_pm_full;
  logic          cmd_periodic;
  logic          cmd_perm_bkp;
  logic          cmd_locate;
  logic          cmd_fitness;
  logic          cmd_baud;
  logic          cmd_rate;
  logic          cmd_orbit;
  logic          sleep_q;
  logic          per_backup_q;

  // a command with a bad checksum is refused outright
  assign cmd_ok       = CMD_VALID & CMD_CHECKSUM_OK & powered_q
                        & (mode_q != MODE_BACKUP);
  assign cmd_standby  = cmd_ok & (CMD_CODE == CMD_STANDBY) & (CMD_ARG == 4'h0);
  assign cmd_pm_full  = cmd_ok & (CMD_CODE == CMD_POWER_MODE) & (CMD_ARG == PM_FULL_ON);
  assign cmd_periodic = cmd_ok & (CMD_CODE == CMD_POWER_MODE)
                        & ((CMD_ARG == PM_PER_BACKUP) | (CMD_ARG == PM_PER_STANDBY));
  assign cmd_perm_bkp = cmd_ok & (CMD_CODE == CMD_POWER_MODE) & (CMD_ARG == PM_PERM_BACKUP);
  assign cmd_locate   = cmd_ok & (CMD_CODE == CMD_POWER_MODE)
                        & ((CMD_ARG == PM_LOC_STANDBY) | (CMD_ARG == PM_LOC_BACKUP));
  assign cmd_fitness  = cmd_ok & (CMD_CODE == CMD_FITNESS);
  // out-of-range settings count as refused commands and are answered with a nak
  assign cmd_baud     = cmd_ok & (CMD_CODE == CMD_BAUD) & ~CMD_ARG[3]
                        & (CMD_ARG[2:0] <= BAUD_115200);
  assign cmd_rate     = cmd_ok & (CMD_CODE == CMD_RATE)
                        & (CMD_ARG >= RATE_MIN) & (CMD_ARG <= RATE_MAX);
  assign cmd_orbit    = cmd_ok & (CMD_CODE == CMD_ORBIT);

  logic in_full;
  logic leave_periodic;
  logic accepted;
  assign in_full = (mode_q == MODE_FULL_ON);
  // periodic backup can only be left while an on period runs
  assign leave_periodic = cmd_pm_full & (mode_q == MODE_PERIODIC)
                          & (~per_backup_q | ~sleep_q);

  // ****************************************
  // mode state machine
  // ****************************************
  logic wake_q;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mode_q    <= MODE_BACKUP;
      powered_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      wake_q <= 1'b0;
      if (!powered_q) begin
        if (supplies_ok) begin
          powered_q <= 1'b1;
          mode_q    <= MODE_FULL_ON;
          wake_q    <= 1'b1;
        end
      end else begin
        case (mode_q)
          MODE_FULL_ON: begin
            // only full-on reaches the low-power modes
            if (cmd_standby) begin
              mode_q <= MODE_STANDBY;
            end else if (cmd_perm_bkp) begin
              mode_q <= MODE_BACKUP;
            end else if (cmd_periodic) begin
              mode_q <= MODE_PERIODIC;
            end else if (cmd_locate) begin
              mode_q <= MODE_LOCATE;
            end else if (cmd_fitness) begin
              mode_q <= MODE_FITNESS;
            end
          end
          MODE_STANDBY: begin
            if (RX_BYTE_VALID) begin
              mode_q <= MODE_FULL_ON;
              wake_q <= 1'b1;
            end
          end
          MODE_BACKUP: begin
            // main supply is cut; only the host request brings it back
            if (request_rise) begin
              mode_q <= MODE_FULL_ON;
              wake_q <= 1'b1;
            end
          end
          MODE_PERIODIC: begin
            if (leave_periodic) begin
              mode_q <= MODE_FULL_ON;
              wake_q <= 1'b1;
            end
          end
          MODE_LOCATE, MODE_FITNESS: begin
            if (cmd_pm_full) begin
              mode_q <= MODE_FULL_ON;
              wake_q <= 1'b1;
            end
          end
          default: begin
            mode_q <= MODE_FULL_ON;
          end
        endcase
      end
    end
  end

  assign accepted = cmd_baud | cmd_rate | cmd_orbit
                    | (in_full & (cmd_standby | cmd_perm_bkp | cmd_periodic))
                    | (in_full & (cmd_locate | cmd_fitness))
                    | leave_periodic
                    | (cmd_pm_full & ((mode_q == MODE_LOCATE) | (mode_q == MODE_FITNESS)));

  // ****************************************
  // acquisition and tracking
  // ****************************************
  logic [31:0] acq_cnt_q;
  logic        tracking_q;
  logic        engine_on;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      acq_cnt_q  <= 32'h0;
      tracking_q <= 1'b0;
    end else if (!engine_on || wake_q) begin
      acq_cnt_q  <= 32'h0;
      tracking_q <= 1'b0;
    end else if (!tracking_q) begin
      // acquisition runs to completion, then tracking takes over
      if (acq_cnt_q == ACQ_CYC - 1) begin
        tracking_q <= 1'b1;
      end else begin
        acq_cnt_q <= acq_cnt_q + 32'h1;
      end
    end
  end

  // ****************************************
  // periodic scheduler
  // ****************************************
  logic [31:0] run_ms_q;
  logic [31:0] sleep_ms_q;
  logic [31:0] ext_run_ms_q;
  logic [31:0] ext_sleep_ms_q;
  logic        ext_q;
  logic        fixed_q;
  logic [31:0] ms_left_q;
  logic [31:0] tick_q;
  logic        ms_tick;
  logic [31:0] on_ms;
  logic [31:0] off_ms;

  assign ms_tick = (tick_q == CYCLES_PER_MS - 1);
  assign on_ms   = ext_q ? ext_run_ms_q : run_ms_q;
  assign off_ms  = ext_q ? ext_sleep_ms_q : sleep_ms_q;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      run_ms_q       <= 32'h0;
      sleep_ms_q     <= 32'h0;
      ext_run_ms_q   <= 32'h0;
      ext_sleep_ms_q <= 32'h0;
      per_backup_q   <= 1'b0;
    end else if (in_full && cmd_periodic) begin
      per_backup_q   <= (CMD_ARG == PM_PER_BACKUP);
      run_ms_q       <= CMD_RUN_MS;
      sleep_ms_q     <= CMD_SLEEP_MS;
      ext_run_ms_q   <= CMD_EXT_RUN_MS;
      ext_sleep_ms_q <= CMD_EXT_SLEEP_MS;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      tick_q    <= 32'h0;
      ms_left_q <= 32'h0;
      sleep_q   <= 1'b0;
      ext_q     <= 1'b0;
      fixed_q   <= 1'b0;
    end else if (mode_q != MODE_PERIODIC) begin
      tick_q    <= 32'h0;
      ms_left_q <= CMD_RUN_MS;
      sleep_q   <= 1'b0;
      ext_q     <= 1'b0;
      fixed_q   <= 1'b0;
    end else begin
      tick_q <= ms_tick ? 32'h0 : tick_q + 32'h1;
      if (!sleep_q && FIX_VALID) begin
        fixed_q <= 1'b1;
      end
      if (ms_tick) begin
        if (ms_left_q > 32'h1) begin
          ms_left_q <= ms_left_q - 32'h1;
        end else if (!sleep_q) begin
          // period outcome picks the pair of lengths for the next cycle
          sleep_q   <= 1'b1;
          ext_q     <= ~(fixed_q | FIX_VALID);
          ms_left_q <= (fixed_q | FIX_VALID) ? sleep_ms_q : ext_sleep_ms_q;
        end else begin
          sleep_q   <= 1'b0;
          fixed_q   <= 1'b0;
          ms_left_q <= on_ms;
        end
      end
    end
  end

  assign engine_on = powered_q & ((mode_q == MODE_FULL_ON) | (mode_q == MODE_LOCATE)
                     | (mode_q == MODE_FITNESS) | ((mode_q == MODE_PERIODIC) & ~sleep_q));

  // ****************************************
  // configuration
  // ****************************************
  logic [2:0] baud_q;
  logic [3:0] rate_q;
  logic       orbit_req_q;
  logic       aug_q;
  logic       intf_q;
  logic       log_q;

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || !powered_q) begin
      baud_q      <= BAUD_RST;
      rate_q      <= RATE_RST;
      orbit_req_q <= ORBIT_RST;
      aug_q       <= AUGMENT_RST;
      intf_q      <= INTERF_RST;
      log_q       <= LOGGING_RST;
    end else begin
      if (cmd_baud) begin
        baud_q <= CMD_ARG[2:0];
      end
      if (cmd_rate) begin
        rate_q <= CMD_ARG;
      end
      if (cmd_orbit) begin
        orbit_req_q <= CMD_ARG[0];
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic standby_like;
  assign standby_like = (mode_q == MODE_STANDBY) | ((mode_q == MODE_PERIODIC) & sleep_q);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      CMD_ACK                <= 1'b0;
      CMD_NAK                <= 1'b0;
      MODE                   <= MODE_BACKUP;
      TRACKING               <= 1'b0;
      RF_POWER_EN            <= 1'b0;
      OSC_POWER_EN           <= 1'b0;
      NAV_EN                 <= 1'b0;
      SENTENCE_EN            <= 1'b0;
      SENTENCE_MASK          <= SENT_RST;
      SERIAL_RX_EN           <= 1'b0;
      RETAIN_AIDING          <= 1'b1;
      HOT_START              <= 1'b0;
      BAUD_SEL               <= BAUD_RST;
      UPDATE_RATE            <= RATE_RST;
      AUGMENT_EN             <= AUGMENT_RST;
      INTERFERENCE_CANCEL_EN <= INTERF_RST;
      POSITION_LOGGING_EN    <= LOGGING_RST;
      ORBIT_PREDICTION_EN    <= ORBIT_RST;
      POWER_CUT_OUT          <= 1'b0;
      POWER_CUT_OE           <= 1'b0;
      SLEEP_PHASE            <= 1'b0;
      EXTENDED_PERIODS       <= 1'b0;
    end else begin
      CMD_ACK       <= accepted;
      CMD_NAK       <= CMD_VALID & powered_q & (mode_q != MODE_BACKUP) & ~accepted;
      MODE          <= mode_q;
      TRACKING      <= tracking_q;
      RF_POWER_EN   <= engine_on;
      OSC_POWER_EN  <= engine_on;
      NAV_EN        <= engine_on;
      SENTENCE_EN   <= engine_on;
      SENTENCE_MASK <= SENT_RST;
      SERIAL_RX_EN  <= powered_q & (mode_q != MODE_BACKUP);
      RETAIN_AIDING <= 1'b1;
      if (wake_q && (mode_q == MODE_FULL_ON)) begin
        HOT_START <= 1'b1;
      end else if (tracking_q) begin
        HOT_START <= 1'b0;
      end
      BAUD_SEL               <= baud_q;
      UPDATE_RATE            <= rate_q;
      AUGMENT_EN             <= aug_q;
      INTERFERENCE_CANCEL_EN <= intf_q;
      POSITION_LOGGING_EN    <= log_q;
      ORBIT_PREDICTION_EN    <= orbit_req_q & (rate_q <= RATE_MIN);
      // open drain: never driven high, only pulled low to cut main supply
      POWER_CUT_OUT          <= 1'b0;
      POWER_CUT_OE           <= (mode_q == MODE_BACKUP) & powered_q
                                | (mode_q == MODE_PERIODIC) & sleep_q & per_backup_q;
      SLEEP_PHASE            <= standby_like | ((mode_q == MODE_PERIODIC) & sleep_q);
      EXTENDED_PERIODS       <= ext_q;
    end
  end
endmodule : gpmc_core

// ==== gpmc_pkg.sv ====
// package: constants and types of the power-mode controller
package gpmc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ    = 250_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned CYCLES_PER_MS  = CLK_FREQ_HZ / MS_PER_S;
  localparam int unsigned ACQ_TIME_MS    = 10;
  localparam int unsigned ACQ_CYCLES     = ACQ_TIME_MS * CYCLES_PER_MS;

  // ****************************************
  // reset values and limits of the configuration
  // ****************************************
  localparam logic [2:0] BAUD_4800       = 3'h0;
  localparam logic [2:0] BAUD_9600       = 3'h1;
  localparam logic [2:0] BAUD_115200     = 3'h6;
  localparam logic [2:0] BAUD_RST        = BAUD_9600;
  localparam logic [3:0] RATE_MIN        = 4'h1;
  localparam logic [3:0] RATE_MAX        = 4'ha;
  localparam logic [3:0] RATE_RST        = RATE_MIN;
  localparam logic [6:0] SENT_RST        = 7'h7f;
  localparam logic       AUGMENT_RST     = 1'b1;
  localparam logic       INTERF_RST      = 1'b1;
  localparam logic       LOGGING_RST     = 1'b0;
  localparam logic       ORBIT_RST       = 1'b0;

  // ****************************************
  // command codes and power-mode arguments after parsing
  // ****************************************
  localparam logic [3:0] CMD_STANDBY     = 4'h1;
  localparam logic [3:0] CMD_POWER_MODE  = 4'h2;
  localparam logic [3:0] CMD_FITNESS     = 4'h3;
  localparam logic [3:0] CMD_BAUD        = 4'h4;
  localparam logic [3:0] CMD_RATE        = 4'h5;
  localparam logic [3:0] CMD_ORBIT       = 4'h6;
  localparam logic [3:0] PM_FULL_ON      = 4'h0;
  localparam logic [3:0] PM_PER_BACKUP   = 4'h1;
  localparam logic [3:0] PM_PER_STANDBY  = 4'h2;
  localparam logic [3:0] PM_PERM_BACKUP  = 4'h4;
  localparam logic [3:0] PM_LOC_STANDBY  = 4'h8;
  localparam logic [3:0] PM_LOC_BACKUP   = 4'h9;

  typedef enum logic [2:0] {
    MODE_FULL_ON,
    MODE_STANDBY,
    MODE_BACKUP,
    MODE_PERIODIC,
    MODE_LOCATE,
    MODE_FITNESS
  } gpmc_mode_type;

endpackage : gpmc_pkg

// ==== gpmc_sync_if.sv ====
// interface: synchronised pin levels passed to the controller core
`timescale 1ns/1ps
interface gpmc_sync_if;
  logic main_ok;
  logic backup_ok;
  logic power_request;
  modport src (output main_ok, output backup_ok, output power_request);
  modport dst (input main_ok, input backup_ok, input power_request);
endinterface : gpmc_sync_if

// ==== gpmc_pin_sync.sv ====
// module: three-stage synchroniser for the asynchronous supply and request pins
`timescale 1ns/1ps
module gpmc_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic main_pin,
  input  wire logic backup_pin,
  input  wire logic request_pin,
  gpmc_sync_if.src  sync
);
  logic [2:0] pins;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] lvl_q;

  assign pins = {request_pin, backup_pin, main_pin};

  // a change is taken only once the second and third stages agree
  for (genvar i = 0; i < 3; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_q[i]  <= 1'b0;
        s2_q[i]  <= 1'b0;
        s3_q[i]  <= 1'b0;
        lvl_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sync.main_ok       = lvl_q[0];
  assign sync.backup_ok     = lvl_q[1];
  assign sync.power_request = lvl_q[2];
endmodule : gpmc_pin_sync

// ==== gpmc_core_properties.sv ====
// checker: port-level properties of the power-mode controller
`timescale 1ns/1ps
module gpmc_core_properties
  import gpmc_pkg::*;
#(
  parameter int unsigned ACQ_CYC = ACQ_CYCLES
) (
  input wire logic       REF_CLK,
  input wire logic       SYS_RST,
  input wire logic       RX_BYTE_VALID,
  input wire logic       CMD_VALID,
  input wire logic       CMD_CHECKSUM_OK,
  input wire logic [3:0] CMD_CODE,
  input wire logic [3:0] CMD_ARG,
  input wire logic       CMD_ACK,
  input wire logic       CMD_NAK,
  input wire logic [2:0] MODE,
  input wire logic       RF_POWER_EN,
  input wire logic       SENTENCE_EN,
  input wire logic       HOT_START,
  input wire logic [3:0] UPDATE_RATE,
  input wire logic       ORBIT_PREDICTION_EN,
  input wire logic       POWER_CUT_OUT,
  input wire logic       POWER_CUT_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // ****************************************
  // properties
  // ****************************************
  answer_cause_a: assert property ((CMD_ACK || CMD_NAK) |-> $past(CMD_VALID) && !(CMD_ACK && CMD_NAK))
    else $error("answer without request");
  bad_sum_nak_a: assert property (CMD_VALID && !CMD_CHECKSUM_OK && MODE != MODE_BACKUP |=> CMD_NAK)
    else $error("bad checksum accepted");
  mode_route_a: assert property ($changed(MODE) |-> $past(MODE) == MODE_FULL_ON || MODE == MODE_FULL_ON)
    else $error("illegal mode change");
  standby_quiet_a: assert property (MODE == MODE_STANDBY |-> !RF_POWER_EN && !SENTENCE_EN)
    else $error("standby still active");
  byte_wakes_a: assert property (MODE == MODE_STANDBY && RX_BYTE_VALID |-> ##[1:3] MODE == MODE_FULL_ON)
    else $error("byte did not wake");
  hot_start_a: assert property (MODE == MODE_STANDBY ##1 MODE == MODE_FULL_ON |-> HOT_START)
    else $error("no hot start");
  orbit_off_a: assert property ((UPDATE_RATE > 4'h1) [*2] |-> !ORBIT_PREDICTION_EN)
    else $error("orbit prediction on at high rate");
  cut_low_a: assert property (CMD_ACK && $past(CMD_CODE) == CMD_POWER_MODE
    && $past(CMD_ARG) == PM_PERM_BACKUP |-> ##[0:2] POWER_CUT_OE)
    else $error("power cut not driven");
  open_drain_a: assert property (!POWER_CUT_OUT)
    else $error("power cut driven high");
  backup_deaf_a: assert property (MODE == MODE_BACKUP && CMD_VALID |=> !CMD_ACK && !CMD_NAK)
    else $error("command answered in backup");
endmodule : gpmc_core_properties

bind gpmc_core gpmc_core_properties #(.ACQ_CYC(ACQ_CYC)) gpmc_core_properties_inst (
  .REF_CLK, .SYS_RST, .RX_BYTE_VALID, .CMD_VALID, .CMD_CHECKSUM_OK, .CMD_CODE, .CMD_ARG,
  .CMD_ACK, .CMD_NAK, .MODE, .RF_POWER_EN, .SENTENCE_EN, .HOT_START, .UPDATE_RATE,
  .ORBIT_PREDICTION_EN, .POWER_CUT_OUT, .POWER_CUT_OE);

// ==== gpmc_host_model.sv ====
// model: host issuing commands, serial bytes and the power request
`timescale 1ns/1ps
module gpmc_host_model (
  input  wire logic   REF_CLK,
  input  wire logic   CMD_ACK,
  input  wire logic   CMD_NAK,
  output logic        HOST_POWER_REQUEST,
  output logic        RX_BYTE_VALID,
  output logic        CMD_VALID,
  output logic        CMD_CHECKSUM_OK,
  output logic [3:0]  CMD_CODE,
  output logic [3:0]  CMD_ARG,
  output logic [31:0] CMD_RUN_MS,
  output logic [31:0] CMD_SLEEP_MS,
  output logic [31:0] CMD_EXT_RUN_MS,
  output logic [31:0] CMD_EXT_SLEEP_MS
);
  initial begin
    HOST_POWER_REQUEST = 1'b0;
    {RX_BYTE_VALID, CMD_VALID, CMD_CHECKSUM_OK} = 3'h0;
    {CMD_CODE, CMD_ARG} = 8'ha5;
    CMD_RUN_MS = 32'h0bb8;
    CMD_SLEEP_MS = 32'h2ee0;
    CMD_EXT_RUN_MS = 32'h4650;
    CMD_EXT_SLEEP_MS = 32'h11940;
  end
  // answer stands for the cycle after the taking edge; fields flip when idle
  task automatic send_cmd(input logic [3:0] code, input logic [3:0] arg, input logic good,
                          output logic [1:0] ans);
    @(posedge REF_CLK);
    #1;
    CMD_CODE = code;
    CMD_ARG = arg;
    CMD_CHECKSUM_OK = good;
    CMD_VALID = 1'b1;
    @(posedge REF_CLK);
    #1;
    ans = {CMD_ACK, CMD_NAK};
    CMD_VALID = 1'b0;
    CMD_CODE = ~code;
    CMD_ARG = ~arg;
    @(posedge REF_CLK);
    #1;
  endtask : send_cmd
  task automatic raise_request();
    @(posedge REF_CLK);
    #1;
    HOST_POWER_REQUEST = 1'b1;
  endtask : raise_request
  task automatic send_byte();
    @(posedge REF_CLK);
    #1;
    RX_BYTE_VALID = 1'b1;
    @(posedge REF_CLK);
    #1;
    RX_BYTE_VALID = 1'b0;
  endtask : send_byte
endmodule : gpmc_host_model

// ==== tb.sv ====
// testbench: self-checking run of the power-mode controller
`timescale 1ns/1ps
module tb;
  import gpmc_pkg::*;
  localparam int unsigned ACQ = 20;
  localparam int unsigned LIMIT = 6000;
  logic REF_CLK, SYS_RST, MAIN_SUPPLY_OK, BACKUP_SUPPLY_OK, HOST_POWER_REQUEST, RX_BYTE_VALID;
  logic CMD_VALID, CMD_CHECKSUM_OK, FIX_VALID, CMD_ACK, CMD_NAK, TRACKING, RF_POWER_EN;
  logic OSC_POWER_EN, NAV_EN, SENTENCE_EN, SERIAL_RX_EN, RETAIN_AIDING, HOT_START, AUGMENT_EN;
  logic INTERFERENCE_CANCEL_EN, POSITION_LOGGING_EN, ORBIT_PREDICTION_EN, POWER_CUT_OUT;
  logic POWER_CUT_OE, SLEEP_PHASE, EXTENDED_PERIODS;
  logic [3:0]  CMD_CODE, CMD_ARG, UPDATE_RATE;
  logic [31:0] CMD_RUN_MS, CMD_SLEEP_MS, CMD_EXT_RUN_MS, CMD_EXT_SLEEP_MS;
  logic [2:0]  MODE, BAUD_SEL;
  logic [6:0]  SENTENCE_MASK;
  logic [1:0]  ans;
  int          err_total, num_checks, cycles;

  gpmc_core #(.ACQ_CYC(ACQ)) gpmc_core_inst (.REF_CLK, .SYS_RST, .MAIN_SUPPLY_OK,
    .BACKUP_SUPPLY_OK, .HOST_POWER_REQUEST, .RX_BYTE_VALID, .CMD_VALID, .CMD_CHECKSUM_OK,
    .CMD_CODE, .CMD_ARG, .CMD_RUN_MS, .CMD_SLEEP_MS, .CMD_EXT_RUN_MS, .CMD_EXT_SLEEP_MS,
    .FIX_VALID, .CMD_ACK, .CMD_NAK, .MODE, .TRACKING, .RF_POWER_EN, .OSC_POWER_EN, .NAV_EN,
    .SENTENCE_EN, .SENTENCE_MASK, .SERIAL_RX_EN, .RETAIN_AIDING, .HOT_START, .BAUD_SEL,
    .UPDATE_RATE, .AUGMENT_EN, .INTERFERENCE_CANCEL_EN, .POSITION_LOGGING_EN,
    .ORBIT_PREDICTION_EN, .POWER_CUT_OUT, .POWER_CUT_OE, .SLEEP_PHASE, .EXTENDED_PERIODS);
  gpmc_host_model gpmc_host_model_inst (.REF_CLK, .CMD_ACK, .CMD_NAK, .HOST_POWER_REQUEST,
    .RX_BYTE_VALID, .CMD_VALID, .CMD_CHECKSUM_OK, .CMD_CODE, .CMD_ARG, .CMD_RUN_MS,
    .CMD_SLEEP_MS, .CMD_EXT_RUN_MS, .CMD_EXT_SLEEP_MS);

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic g);
    gpmc_host_model_inst.send_cmd(c, a, g, ans);
  endtask : cmd
  // bounded wait for a mode, then judged
  task automatic wait_mode(input logic [2:0] m, input int n);
    for (int i = 0; i < n && MODE !== m; i++) @(posedge REF_CLK);
    #1;
    check("mode", MODE, m);
  endtask : wait_mode
  task automatic wait_track();
    for (int i = 0; i < ACQ + 10 && TRACKING !== 1'b1; i++) @(posedge REF_CLK);
    #1;
    check("tracking", TRACKING, 1'b1);
  endtask : wait_track
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    wait_mode(MODE_FULL_ON, 20);
    check("baud", BAUD_SEL, BAUD_RST);
    check("rate", UPDATE_RATE, RATE_RST);
    check("sentences", SENTENCE_MASK, 7'h7f);
    check("feat", {AUGMENT_EN, INTERFERENCE_CANCEL_EN, POSITION_LOGGING_EN, ORBIT_PREDICTION_EN},
          4'hc);
    wait_track();
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_config();
    cmd(CMD_BAUD, 4'h0, 1'b1);
    check("baud lo", {ans, BAUD_SEL}, {2'h2, BAUD_4800});
    cmd(CMD_BAUD, 4'h6, 1'b1);
    check("baud hi", {ans, BAUD_SEL}, {2'h2, BAUD_115200});
    cmd(CMD_BAUD, 4'h7, 1'b1);
    check("baud bad", ans, 2'h1);
    cmd(CMD_RATE, 4'hb, 1'b1);
    check("rate bad", ans, 2'h1);
    cmd(CMD_RATE, RATE_MAX, 1'b1);
    check("rate max", {ans, UPDATE_RATE}, {2'h2, RATE_MAX});
    cmd(CMD_ORBIT, 4'h1, 1'b1);
    check("orbit fast", ORBIT_PREDICTION_EN, 1'b0);
    cmd(CMD_RATE, RATE_MIN, 1'b1);
    cmd(CMD_ORBIT, 4'h1, 1'b1);
    check("orbit slow", ORBIT_PREDICTION_EN, 1'b1);
    cmd(CMD_STANDBY, 4'h0, 1'b0);
    check("bad sum", ans, 2'h1);
    $display("test config done");
  endtask : t_config
  task automatic t_standby();
    cmd(CMD_STANDBY, 4'h0, 1'b1);
    check("standby ack", ans, 2'h2);
    wait_mode(MODE_STANDBY, 3);
    check("radio", {RF_POWER_EN, OSC_POWER_EN, NAV_EN, SENTENCE_EN, SERIAL_RX_EN}, 5'h01);
    gpmc_host_model_inst.send_byte();
    wait_mode(MODE_FULL_ON, 4);
    check("hot start", HOT_START, 1'b1);
    wait_track();
    $display("test standby done");
  endtask : t_standby
  task automatic t_periodic();
    logic [3:0] args[5] = '{PM_PER_STANDBY, PM_PER_BACKUP, PM_LOC_STANDBY, PM_LOC_BACKUP, 4'h0};
    logic [2:0] mds[5] = '{MODE_PERIODIC, MODE_PERIODIC, MODE_LOCATE, MODE_LOCATE, MODE_FITNESS};
    for (int i = 0; i < 5; i++) begin
      cmd(i < 4 ? CMD_POWER_MODE : CMD_FITNESS, args[i], 1'b1);
      check("entry ack", ans, 2'h2);
      wait_mode(mds[i], 3);
      cmd(CMD_STANDBY, 4'h0, 1'b1);
      check("no direct", ans, 2'h1);
      cmd(CMD_POWER_MODE, PM_FULL_ON, 1'b1);
      check("exit ack", ans, 2'h2);
      wait_mode(MODE_FULL_ON, 3);
    end
    $display("test periodic done");
  endtask : t_periodic
  task automatic t_backup();
    cmd(CMD_POWER_MODE, PM_PERM_BACKUP, 1'b1);
    check("backup ack", ans, 2'h2);
    wait_mode(MODE_BACKUP, 3);
    check("cut", {POWER_CUT_OE, POWER_CUT_OUT}, 2'h2);
    cmd(CMD_STANDBY, 4'h0, 1'b1);
    check("deaf", ans, 2'h0);
    gpmc_host_model_inst.send_byte();
    check("stays", MODE, MODE_BACKUP);
    gpmc_host_model_inst.raise_request();
    wait_mode(MODE_FULL_ON, 12);
    check("cut off", POWER_CUT_OE, 1'b0);
    $display("test backup done");
  endtask : t_backup

  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      results();
    end
  end
  initial begin
    {SYS_RST, MAIN_SUPPLY_OK, BACKUP_SUPPLY_OK, FIX_VALID} = 4'hf;
    repeat (5) @(posedge REF_CLK);
    #1 SYS_RST = 1'b0;
    t_defaults();
    t_config();
    t_standby();
    t_periodic();
    t_backup();
    results();
  end
endmodule : tb
